/* File: core/hsf_microframe_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Microframe period timer
module hsf_microframe_timer #(
	parameter int unsigned MicroframeCycles = hsf_pkg::MICROFRAME_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst,
	hsf_timer_if.timer tmr
);
	localparam logic [hsf_pkg::TMR_W-1:0] LAST = hsf_pkg::TMR_W'(MicroframeCycles - 1);

	hsf_pkg::hsf_tmr_state_type state_r;
	hsf_pkg::hsf_tmr_state_type state_nxt;
	logic [hsf_pkg::TMR_W-1:0] cnt_r;
	logic [hsf_pkg::TMR_W-1:0] cnt_nxt;
	logic tick_r;
	logic tick_nxt;

	// ==========================================================
	// Next state
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		tick_nxt = 1'b0;
		case (state_r)
			hsf_pkg::TMR_STOPPED: begin
				cnt_nxt = hsf_pkg::TMR_RESET;
				if (tmr.run) begin
					state_nxt = hsf_pkg::TMR_RUNNING;
				end
			end
			hsf_pkg::TMR_RUNNING: begin
				if (!tmr.run) begin
					state_nxt = hsf_pkg::TMR_STOPPED;
					cnt_nxt = hsf_pkg::TMR_RESET;
				end else if (tmr.restart) begin
					// A new count value starts a fresh microframe
					cnt_nxt = hsf_pkg::TMR_RESET;
				end else if (cnt_r == LAST) begin
					cnt_nxt = hsf_pkg::TMR_RESET;
					tick_nxt = 1'b1;
				end else begin
					cnt_nxt = cnt_r + hsf_pkg::TMR_ONE;
				end
			end
			default: begin
				state_nxt = hsf_pkg::TMR_STOPPED;
			end
		endcase
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_r <= hsf_pkg::TMR_STOPPED;
			cnt_r <= hsf_pkg::TMR_RESET;
			tick_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tmr.tick = tick_r;
endmodule : hsf_microframe_timer
`default_nettype wire

/* File: core/hsf_pkg.sv */
`default_nettype none
// ==========================================================
// Shared constants of the status and frame index block
package hsf_pkg;
	// ==========================================================
	// Register map, byte addresses on the processor port
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h24;
	localparam logic [ADDR_W-1:0] INTEN_OFS = 8'h28;
	localparam logic [ADDR_W-1:0] MFCOUNT_OFS = 8'h2c;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;
	localparam logic [BE_W-1:0] FULL_WORD_BE = 4'hf;
	localparam logic [DATA_W-1:0] ZERO_WORD = 32'h00000000;
	// ==========================================================
	// Status fields
	localparam int ROLLOVER_BIT = 3;
	localparam int PORTCHG_BIT = 2;
	localparam logic STATUS_FLAG_RESET = 1'b0;
	// ==========================================================
	// Microframe counter and frame list index
	localparam int COUNT_W = 14;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 14'h0000;
	localparam logic [COUNT_W-1:0] COUNT_ONE = 14'h0001;
	localparam int INDEX_LSB = 3;
	localparam int INDEX_W = 10;
	localparam logic [INDEX_W-1:0] INDEX_RESET = 10'h000;
	localparam int LIST_SIZE_W = 2;
	localparam logic [LIST_SIZE_W-1:0] LIST_SIZE_1024 = 2'h0;
	localparam logic [LIST_SIZE_W-1:0] LIST_SIZE_512 = 2'h1;
	localparam logic [LIST_SIZE_W-1:0] LIST_SIZE_256 = 2'h2;
	localparam logic [COUNT_W-1:0] WRAP_MASK_1024 = 14'h3fff;
	localparam logic [COUNT_W-1:0] WRAP_MASK_512 = 14'h1fff;
	localparam logic [COUNT_W-1:0] WRAP_MASK_256 = 14'h0fff;
	// ==========================================================
	// Ports
	localparam int NUM_PORTS = 3;
	localparam logic [NUM_PORTS-1:0] PORTS_RESET = 3'h0;
	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int MICROFRAME_NS = 125000;
	localparam int MICROFRAME_CYCLES = MICROFRAME_NS / CLK_PERIOD_NS;
	localparam int TMR_W = 16;
	localparam logic [TMR_W-1:0] TMR_RESET = 16'h0000;
	localparam logic [TMR_W-1:0] TMR_ONE = 16'h0001;
	typedef enum logic {TMR_STOPPED, TMR_RUNNING} hsf_tmr_state_type;
endpackage : hsf_pkg
`default_nettype wire

/* File: core/hsf_status_frame_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// - Status flags clear only by writing one; writing zero keeps them.
// - Set rollover flag, bit 3, on every second wrap of the frame list index to zero.
// - Set port change flag, bit 2, on unowned port change or forced resume rise of a suspended port.
// - Status register holds no per-transaction bus results.
// - Interrupt enable register accepts accesses; all bits reserved, enable nothing.
// - Counter updates once every 125 microseconds while running.
// - Frame list entry chosen by counter bits upper bit down to bit 3.
// - Index width follows the programmed list size setting.
// - Whole-word counter writes change the frame number of later start-of-frame packets.
// - Counter bits 13 to 0 give frame number and index; upper bits zero.
// - Counter increments by one at the end of every microframe.
// - Run control set executes the schedule; cleared stops it.
module hsf_status_frame_regs #(
	parameter int unsigned MicroframeCycles = hsf_pkg::MICROFRAME_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic regSelect,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [hsf_pkg::ADDR_W-1:0] regAddr,
	input wire logic [hsf_pkg::BE_W-1:0] regByteEn,
	input wire logic [hsf_pkg::DATA_W-1:0] regWdata,
	input wire logic runStop,
	input wire logic [hsf_pkg::LIST_SIZE_W-1:0] listSizeField,
	input wire logic [hsf_pkg::NUM_PORTS-1:0] portChange,
	input wire logic [hsf_pkg::NUM_PORTS-1:0] portOwnershipBit,
	input wire logic [hsf_pkg::NUM_PORTS-1:0] forcedResumeBit,
	input wire logic [hsf_pkg::NUM_PORTS-1:0] portSuspended,
	output logic [hsf_pkg::DATA_W-1:0] regRdata,
	output logic regRvalid,
	output logic [hsf_pkg::COUNT_W-1:0] sofFrameNumber,
	output logic [hsf_pkg::INDEX_W-1:0] frameListIndex,
	output logic listRolloverFlag,
	output logic portChangeFlag
);
	// ==========================================================
	// Decoding helpers

	// Bits of the counter that run up to and including the wrap point
	function automatic logic [hsf_pkg::COUNT_W-1:0] wrapMask(
		input logic [hsf_pkg::LIST_SIZE_W-1:0] size
	);
		logic [hsf_pkg::COUNT_W-1:0] m;
		m = hsf_pkg::WRAP_MASK_1024;
		if (size == hsf_pkg::LIST_SIZE_512) begin
			m = hsf_pkg::WRAP_MASK_512;
		end else if (size == hsf_pkg::LIST_SIZE_256) begin
			m = hsf_pkg::WRAP_MASK_256;
		end
		return m;
	endfunction : wrapMask

	// Bits that form the list position, one below the wrap point
	function automatic logic [hsf_pkg::COUNT_W-1:0] indexMask(
		input logic [hsf_pkg::LIST_SIZE_W-1:0] size
	);
		return wrapMask(size) >> 1;
	endfunction : indexMask

	// Frame list entry: counter bits from the list's upper bit down to bit 3
	function automatic logic [hsf_pkg::INDEX_W-1:0] listIndexOf(
		input logic [hsf_pkg::COUNT_W-1:0] count,
		input logic [hsf_pkg::LIST_SIZE_W-1:0] size
	);
		logic [hsf_pkg::COUNT_W-1:0] masked;
		masked = (count & indexMask(size)) >> hsf_pkg::INDEX_LSB;
		return masked[hsf_pkg::INDEX_W-1:0];
	endfunction : listIndexOf

	// Register address decode used by both read and write paths
	function automatic logic isAddr(
		input logic [hsf_pkg::ADDR_W-1:0] addr,
		input logic [hsf_pkg::ADDR_W-1:0] ofs
	);
		return addr == ofs;
	endfunction : isAddr

	// Status image: only the two implemented flags, reserved bits read zero
	function automatic logic [hsf_pkg::DATA_W-1:0] statusWord(
		input logic rollover,
		input logic portChg
	);
		logic [hsf_pkg::DATA_W-1:0] w;
		w = hsf_pkg::ZERO_WORD;
		w[hsf_pkg::ROLLOVER_BIT] = rollover;
		w[hsf_pkg::PORTCHG_BIT] = portChg;
		return w;
	endfunction : statusWord

	// Counter image: bits above the counter are reserved and read zero
	function automatic logic [hsf_pkg::DATA_W-1:0] countWord(
		input logic [hsf_pkg::COUNT_W-1:0] count
	);
		logic [hsf_pkg::DATA_W-1:0] w;
		w = hsf_pkg::ZERO_WORD;
		w[hsf_pkg::COUNT_W-1:0] = count;
		return w;
	endfunction : countWord

	// Whole-word check on the byte enables
	function automatic logic isFullWord(
		input logic [hsf_pkg::BE_W-1:0] be
	);
		return be == hsf_pkg::FULL_WORD_BE;
	endfunction : isFullWord

	// ==========================================================
	// Timer link
	hsf_timer_if tmrLink ();

	hsf_microframe_timer #(
		.MicroframeCycles(MicroframeCycles)
	) uTimer (
		.clk_sys(clk_sys),
		.rst(rst),
		.tmr(tmrLink.timer)
	);

	// ==========================================================
	// Counter state
	logic [hsf_pkg::COUNT_W-1:0] count_r;
	logic [hsf_pkg::COUNT_W-1:0] count_nxt;
	logic [hsf_pkg::INDEX_W-1:0] index_r;
	logic [hsf_pkg::INDEX_W-1:0] index_nxt;

	// ==========================================================
	// Status state
	logic rollover_r;
	logic rollover_nxt;
	logic portChg_r;
	logic portChg_nxt;
	logic [hsf_pkg::NUM_PORTS-1:0] resumePrev_r;
	logic [hsf_pkg::NUM_PORTS-1:0] resumePrev_nxt;

	// ==========================================================
	// Read port state
	logic [hsf_pkg::DATA_W-1:0] rdata_r;
	logic [hsf_pkg::DATA_W-1:0] rdata_nxt;
	logic rvalid_r;
	logic rvalid_nxt;

	// ==========================================================
	// Access qualification
	logic wrAccess;
	logic rdAccess;
	logic statusWrite;
	logic countWrite;
	logic [hsf_pkg::NUM_PORTS-1:0] portEvent;

	assign wrAccess = regSelect & regWrite;
	// Both strobes high at once is taken as a write only
	assign rdAccess = regSelect & regRead & ~regWrite;
	assign statusWrite = wrAccess & isAddr(regAddr, hsf_pkg::STATUS_OFS);
	// Only whole-word writes load the counter; half-word writes are dropped
	assign countWrite = wrAccess & isAddr(regAddr, hsf_pkg::MFCOUNT_OFS) & isFullWord(regByteEn);

	// ==========================================================
	// Per-port change sources
	genvar p;
	generate
		for (p = 0; p < hsf_pkg::NUM_PORTS; p++) begin : gPort
			logic resumeRise;
			// A forced resume counts only on its rising edge while suspended
			assign resumeRise = forcedResumeBit[p] & ~resumePrev_r[p] & portSuspended[p];
			// Change bits of owned ports belong to the companion controller and are masked; resume rises are not
			assign portEvent[p] = (portChange[p] & ~portOwnershipBit[p]) | resumeRise;
		end
	endgenerate

	assign tmrLink.run = runStop;
	// A load restarts the period so the new number lasts a whole microframe
	assign tmrLink.restart = countWrite;

	// ==========================================================
	// Status events and software clears
	logic stepNow;
	logic wrapNow;
	logic clearRollover;
	logic clearPortChg;
	logic setPortChg;

	// A step needs the run level at the tick itself; a tick in flight at stop is dropped
	assign stepNow = runStop & tmrLink.tick;
	assign clearRollover = statusWrite & regWdata[hsf_pkg::ROLLOVER_BIT];
	assign clearPortChg = statusWrite & regWdata[hsf_pkg::PORTCHG_BIT];
	assign setPortChg = |portEvent;

	// ==========================================================
	// Counter and list index next values
	always_comb begin
		wrapNow = 1'b0;
		count_nxt = count_r;
		// A load wins over a step; loading while running is left to software
		if (countWrite) begin
			// Upper bits are dropped so they always read as zero
			count_nxt = regWdata[hsf_pkg::COUNT_W-1:0];
		end else if (stepNow) begin
			wrapNow = (count_r & wrapMask(listSizeField)) == wrapMask(listSizeField);
			count_nxt = count_r + hsf_pkg::COUNT_ONE;
		end
		index_nxt = listIndexOf(count_nxt, listSizeField);
	end

	// ==========================================================
	// Status flag next values
	always_comb begin
		rollover_nxt = rollover_r;
		portChg_nxt = portChg_r;
		resumePrev_nxt = forcedResumeBit;
		// Clear first, then set, so an event in the clearing cycle survives
		if (clearRollover) begin
			rollover_nxt = 1'b0;
		end
		if (clearPortChg) begin
			portChg_nxt = 1'b0;
		end
		if (wrapNow) begin
			rollover_nxt = 1'b1;
		end
		if (setPortChg) begin
			portChg_nxt = 1'b1;
		end
	end

	// ==========================================================
	// Read data
	always_comb begin
		rdata_nxt = hsf_pkg::ZERO_WORD;
		rvalid_nxt = rdAccess;
		if (rdAccess) begin
			if (isAddr(regAddr, hsf_pkg::STATUS_OFS)) begin
				// Only controller state flags, nothing about bus transactions
				rdata_nxt = statusWord(rollover_r, portChg_r);
			end else if (isAddr(regAddr, hsf_pkg::INTEN_OFS)) begin
				// Writes are taken and discarded; nothing is enabled
				rdata_nxt = hsf_pkg::ZERO_WORD;
			end else if (isAddr(regAddr, hsf_pkg::MFCOUNT_OFS)) begin
				rdata_nxt = countWord(count_r);
			end else begin
				// Unmapped addresses read as zero
				rdata_nxt = hsf_pkg::ZERO_WORD;
			end
		end
	end

	// ==========================================================
	// Counter registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			count_r <= hsf_pkg::COUNT_RESET;
			index_r <= hsf_pkg::INDEX_RESET;
		end else begin
			count_r <= count_nxt;
			index_r <= index_nxt;
		end
	end

	// ==========================================================
	// Status registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rollover_r <= hsf_pkg::STATUS_FLAG_RESET;
			portChg_r <= hsf_pkg::STATUS_FLAG_RESET;
			resumePrev_r <= hsf_pkg::PORTS_RESET;
		end else begin
			rollover_r <= rollover_nxt;
			portChg_r <= portChg_nxt;
			resumePrev_r <= resumePrev_nxt;
		end
	end

	// ==========================================================
	// Read port registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata_r <= hsf_pkg::ZERO_WORD;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign regRdata = rdata_r;
	assign regRvalid = rvalid_r;

	assign sofFrameNumber = count_r;
	assign frameListIndex = index_r;

	assign listRolloverFlag = rollover_r;
	assign portChangeFlag = portChg_r;
endmodule : hsf_status_frame_regs
`default_nettype wire

/* File: core/hsf_timer_if.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Link between the register bank and the microframe timer
interface hsf_timer_if;
	logic run;
	logic restart;
	logic tick;
	modport ctrl (output run, output restart, input tick);
	modport timer (input run, input restart, output tick);
endinterface : hsf_timer_if
`default_nettype wire

/* File: verif/hsf_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host processor on the register port
module hsf_host_model (
	input wire logic clk_sys,
	input wire logic regRvalid,
	input wire logic [31:0] regRdata,
	output logic regSelect,
	output logic regWrite,
	output logic regRead,
	output logic [7:0] regAddr,
	output logic [3:0] regByteEn,
	output logic [31:0] regWdata
);
	// Released lines flip so stale values are never mistaken for fresh ones
	task automatic idle;
		regSelect = 1'b0;
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = ~regAddr;
		regByteEn = ~regByteEn;
		regWdata = ~regWdata;
	endtask : idle
	initial begin
		regAddr = 8'h00;
		regByteEn = 4'h0;
		regWdata = 32'h0;
		idle();
	end
	task automatic write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge clk_sys);
		#1;
		regSelect = 1'b1;
		regWrite = 1'b1;
		regAddr = a;
		regByteEn = be;
		regWdata = d & ((a == 8'h24) ? 32'hc : (a == 8'h2c) ? 32'h3fff : 32'hffffffff);
		@(posedge clk_sys);
		#1;
		idle();
	endtask : write
	task automatic read(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		#1;
		regSelect = 1'b1;
		regRead = 1'b1;
		regAddr = a;
		@(posedge clk_sys);
		#1;
		idle();
		d = regRvalid ? regRdata : 'x;
	endtask : read
endmodule : hsf_host_model
`default_nettype wire

/* File: verif/hsf_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checks of the status and frame index block
module hsf_properties (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic regSelect,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [3:0] regByteEn,
	input wire logic [31:0] regWdata,
	input wire logic runStop,
	input wire logic [1:0] listSizeField,
	input wire logic [2:0] portChange,
	input wire logic [2:0] portOwnershipBit,
	input wire logic [31:0] regRdata,
	input wire logic regRvalid,
	input wire logic [13:0] sofFrameNumber,
	input wire logic [9:0] frameListIndex,
	input wire logic listRolloverFlag,
	input wire logic portChangeFlag
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire rd = regSelect & regRead & ~regWrite;
	wire wr = regSelect & regWrite;
	wire cw = wr && regAddr == 8'h2c && regByteEn == 4'hf;
	wire clr = wr && regAddr == 8'h24 && regWdata[3];
	// ==========================================================
	// Assertions
	chk_read_answer: assert property (rd |=> regRvalid) else $error("read unanswered");
	chk_inten_zero: assert property (rd && regAddr == 8'h28 |=> regRdata == 0) else $error("enable reg nonzero");
	chk_status_read: assert property (rd && regAddr == 8'h24 |=>
		regRdata == {$past(listRolloverFlag), $past(portChangeFlag), 2'h0}) else $error("status read wrong");
	chk_count_write: assert property (cw |=> sofFrameNumber == $past(regWdata[13:0])) else $error("count write lost");
	chk_count_step: assert property (!$past(cw) && $changed(sofFrameNumber) |->
		sofFrameNumber == $past(sofFrameNumber) + 14'h1) else $error("count step not one");
	// A tick in flight at stop is already gated off by runStop; the three idle cycles are only margin
	chk_count_stop: assert property (!runStop [*3] ##0 !cw |=> $stable(sofFrameNumber)) else $error("count moved");
	chk_index_map: assert property (listSizeField == 0 && $stable(listSizeField) |->
		frameListIndex == sofFrameNumber[12:3]) else $error("index wrong");
	chk_rollover_set: assert property (!$past(cw) && listSizeField == 0 && $past(sofFrameNumber) == 14'h3fff
		&& sofFrameNumber == 0 |-> listRolloverFlag) else $error("rollover missed");
	chk_w1c_clear: assert property (!runStop [*3] ##0 clr |=> !listRolloverFlag) else $error("clear ignored");
	chk_flag_keep: assert property (listRolloverFlag && !clr |=> listRolloverFlag) else $error("flag lost");
	chk_port_set: assert property (|(portChange & ~portOwnershipBit) |=> portChangeFlag) else $error("port flag missed");
	cov_rollover: cover property ($rose(listRolloverFlag));
	cov_port: cover property ($rose(portChangeFlag));
	cov_count_write: cover property (cw);
endmodule : hsf_properties
bind hsf_status_frame_regs hsf_properties i_hsf_properties (.*);
`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Self-checking bench of the status and frame index block
module testbench;
	typedef struct {logic [7:0] a; logic [3:0] be; logic [31:0] d; logic [31:0] e;} hsf_row_type;
	logic clk_sys, rst, runStop, regSelect, regWrite, regRead, regRvalid, listRolloverFlag, portChangeFlag;
	logic [1:0] listSizeField;
	logic [2:0] portChange, portOwnershipBit, forcedResumeBit, portSuspended;
	logic [7:0] regAddr;
	logic [3:0] regByteEn;
	logic [31:0] regWdata, regRdata, rdv;
	logic [13:0] sofFrameNumber;
	logic [9:0] frameListIndex;
	logic [9:0] idx [3] = '{10'h3ff, 10'h1ff, 10'h0ff};
	int errors, compares, n, i;
	hsf_row_type rows [6] = '{'{8'h2c, 4'hf, 32'h1234, 32'h1234}, '{8'h2c, 4'h3, 32'h55, 32'h1234},
		'{8'h28, 4'hf, 32'hffffffff, 32'h0}, '{8'h24, 4'hf, 32'hc, 32'h0},
		'{8'h40, 4'hf, 32'h12345678, 32'h0}, '{8'h2c, 4'hf, 32'h3fff, 32'h3fff}};
	// Short microframe keeps the run brief
	hsf_status_frame_regs #(.MicroframeCycles(8)) i_hsf_status_frame_regs (.*);
	hsf_host_model i_hsf_host_model (.*);
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic summarize;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize
	task automatic waitSof(input logic [13:0] v);
		n = 0;
		while (sofFrameNumber !== v && n < 200) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (n >= 200) begin
			errors++;
			summarize();
		end
	endtask : waitSof
	task automatic pulse(input logic [2:0] p);
		portChange = p;
		@(posedge clk_sys);
		#1;
		portChange = 3'h0;
		@(posedge clk_sys);
		#1;
	endtask : pulse
	initial begin
		errors = 0;
		compares = 0;
		rst = 1'b1;
		runStop = 1'b0;
		listSizeField = 2'h0;
		portChange = 3'h0;
		portOwnershipBit = 3'h0;
		forcedResumeBit = 3'h0;
		portSuspended = 3'h0;
		repeat (2) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		i_hsf_host_model.read(8'h2c, rdv);
		check("count reset", rdv, 32'h0);
		for (i = 0; i < 6; i++) begin
			i_hsf_host_model.write(rows[i].a, rows[i].be, rows[i].d);
			i_hsf_host_model.read(rows[i].a, rdv);
			check("row read", rdv, rows[i].e);
		end
		runStop = 1'b1;
		waitSof(14'h0);
		check("wrap", {frameListIndex, listRolloverFlag}, {10'h0, 1'b1});
		waitSof(14'h1);
		check("period", n, 8);
		runStop = 1'b0;
		repeat (20) @(posedge clk_sys);
		#1;
		check("stopped", sofFrameNumber, 14'h1);
		i_hsf_host_model.write(8'h24, 4'hf, 32'h0);
		check("zero keeps", listRolloverFlag, 1'b1);
		i_hsf_host_model.write(8'h24, 4'hf, 32'h8);
		check("one clears", listRolloverFlag, 1'b0);
		portOwnershipBit = 3'h2;
		pulse(3'h2);
		check("owned port", portChangeFlag, 1'b0);
		pulse(3'h4);
		i_hsf_host_model.read(8'h24, rdv);
		check("port status", rdv, 32'h4);
		i_hsf_host_model.write(8'h24, 4'hf, 32'h4);
		check("port clear", portChangeFlag, 1'b0);
		portSuspended = 3'h1;
		forcedResumeBit = 3'h1;
		repeat (2) @(posedge clk_sys);
		#1;
		check("resume", portChangeFlag, 1'b1);
		for (i = 0; i < 3; i++) begin
			listSizeField = i[1:0];
			i_hsf_host_model.write(8'h2c, 4'hf, 32'h1ff8);
			check("index", frameListIndex, idx[i]);
		end
		listSizeField = 2'h1;
		i_hsf_host_model.write(8'h2c, 4'hf, 32'h1fff);
		runStop = 1'b1;
		waitSof(14'h2000);
		check("wrap 512", {frameListIndex, listRolloverFlag}, {10'h0, 1'b1});
		rst = 1'b1;
		#1;
		check("reset", {sofFrameNumber, listRolloverFlag, portChangeFlag, regRvalid}, 32'h0);
		runStop = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		i_hsf_host_model.read(8'h2c, rdv);
		check("count after reset", rdv, 32'h0);
		summarize();
	end
endmodule : testbench
`default_nettype wire
